// ---- fill_ecc_regs.svh ----
`ifndef FILL_ECC_REGS_SVH
`define FILL_ECC_REGS_SVH
// register word offsets (byte addresses)
`define OFS_CONTROL      8'h00
`define OFS_ERR_STATUS   8'h04
`define OFS_ERR_ADDR_LO  8'h08
`define OFS_ERR_ADDR_HI  8'h0C
`define OFS_SYNDROME     8'h10
`define OFS_DCACHE_STAT  8'h14
`define OFS_IFETCH_STAT  8'h18
`define OFS_MEMMGMT_STAT 8'h1C
`define OFS_FAULT_VA     8'h20
`define OFS_EVENTS       8'h24
// field positions
`define BIT_CRD_EN       0
`define BIT_MACHINE_CHECK_EN      1
`define BIT_LOAD_ECC     0
`define BIT_TPAR_P0      1
`define BIT_TPAR_P1      2
`define BIT_CRD_PEND     0
`define BIT_MACHINE_CHECK_PEND    1
// reset values
`define RST_CONTROL      2'h3
`define RST_SYN          8'h00
`endif

// ---- fill_ecc_pkg.sv ----
package fill_ecc_pkg;
  // logged error source
  typedef enum logic [3:0] {
    ERR_NONE         = 4'b0000,
    ERR_IFETCH_MEM1  = 4'b0001,
    ERR_DFETCH_MEM1  = 4'b0010,
    ERR_PROBE_SEC1   = 4'b0011,
    ERR_IFETCH_SEC2  = 4'b0100,
    ERR_DFETCH_SEC2  = 4'b0101,
    ERR_IFETCH_MEM2  = 4'b0110,
    ERR_DFETCH_MEM2  = 4'b0111
  } err_code_e;
  // load-used correction flow
  typedef enum logic [2:0] {
    FL_IDLE  = 3'b000,
    FL_WAIT  = 3'b001,
    FL_EVICT = 3'b010,
    FL_WBACK = 3'b011,
    FL_RETRY = 3'b100
  } flow_e;
endpackage : fill_ecc_pkg

// ---- fill_ecc_error_logging.sv ----
// Contract
// [R1] secondary victim error: forward raw, interrupt, no log
// [R2] victim on double miss: no log, interrupt
// [R3] victim during evict-block: forward raw, silent
// [R4] ifetch memory single error: bad parity, flush, status
// [R5] address register captures fill block bits 42:6
// [R6] single fill/probe errors latch both syndromes
// [R7] ifetch single error: immediate machine check plus interrupt
// [R8] unused data fill error: raw write, log, interrupt
// [R9] used faulty quadword: load queue holds state
// [R10] replay trap and map stall until corrected
// [R11] error read request: evict and write back block
// [R12] used data fill: status, load flag, retry, interrupt
// [R13] speculative load error: interrupt only, no log
// [R14] probe single error: forward raw, log, interrupt
// [R15] double fill errors logged with four source codes
// [R16] double error machine check deferred in firmware mode
// [R17] double memory fill written with original check bits
// [R18] status exact even if address is stale
// [R19] icache parity: flush, parity flag, interrupt
// [R20] dtag parity at issue: data fault, flag, address
// [R21] dtag parity on retry: machine check, pipe flag
// [R22] logged record held until software clears it
`timescale 1ns/100ps
`include "fill_ecc_regs.svh"
module fill_ecc_error_logging
  import fill_ecc_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // victim read events
  input  wire logic        VICTIM_ECC_ERR,
  input  wire logic        VICTIM_EVICT_BLOCK,
  // fill and probe error events
  input  wire logic        FILL_ERR,
  input  wire logic        FILL_DOUBLE,
  input  wire logic        FILL_ICACHE,
  input  wire logic        FILL_FROM_MEM,
  input  wire logic        FILL_LOAD_USED,
  input  wire logic        FILL_SPECULATIVE,
  input  wire logic        PROBE_ERR,
  input  wire logic [42:6] ERR_BLOCK_ADDR,
  input  wire logic [7:0]  ERR_SYN0,
  input  wire logic [7:0]  ERR_SYN1,
  input  wire logic        READ_ERR_REQ,
  // parity events
  input  wire logic        ICACHE_PARITY_ERR,
  input  wire logic        DTAG_PERR_ISSUE,
  input  wire logic        DTAG_PERR_RETRY,
  input  wire logic        DTAG_PERR_PIPE1,
  input  wire logic [31:0] FAULT_VADDR,
  input  wire logic        PRIVILEGED_FIRMWARE_MODE,
  // exceptions
  output logic             CORRECTED_READ_INTERRUPT,
  output logic             MACHINE_CHECK_POST,
  output logic             MACHINE_CHECK_TAKE,
  output logic             DATA_FAULT,
  // cache and pipeline actions
  output logic             FORWARD_UNCORRECTED,
  output logic             ICACHE_BAD_PARITY,
  output logic             ICACHE_FLUSH,
  output logic             WRITE_RAW_CHECKBITS,
  output logic             LOADQ_HOLD,
  output logic             REPLAY_TRAP,
  output logic             MAP_STALL,
  output logic             SCRUB_EVICT,
  output logic             SCRUB_WRITEBACK,
  output logic             LOAD_RETRY
);

  // registers
  logic [1:0]  control_q;
  err_code_e   status_q;
  logic [42:6] addr_q;
  logic [7:0]  syn0_q;
  logic [7:0]  syn1_q;
  logic [2:0]  dstat_q;
  logic        ipar_q;
  logic        dtag_q;
  logic [31:0] va_q;
  logic        crd_q;
  logic        machine_check_q;
  logic        imm_q;
  logic        take_q;
  flow_e       flow_q;
  flow_e       flow_d;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        fwd_q;
  logic        badpar_q;
  logic        flush_q;
  logic        raw_q;
  logic        replay_q;
  logic        fault_q;
  logic        hold_q, evict_q, wback_q, retry_q;

  // bus decode
  wire         req      = WB_CYC_I & WB_STB_I;
  wire         wr_en    = req & WB_WE_I & ack_q & WB_SEL_I[0];
  wire         wr_ctrl  = wr_en & (WB_ADR_I == `OFS_CONTROL);
  wire         clr_log  = wr_en & (WB_ADR_I == `OFS_ERR_STATUS);
  wire         clr_dst  = wr_en & (WB_ADR_I == `OFS_DCACHE_STAT);
  wire         clr_ist  = wr_en & (WB_ADR_I == `OFS_IFETCH_STAT);
  wire         clr_mms  = wr_en & (WB_ADR_I == `OFS_MEMMGMT_STAT);
  wire         clr_evt  = wr_en & (WB_ADR_I == `OFS_EVENTS);
  wire         crd_en   = control_q[`BIT_CRD_EN];
  wire         machine_check_en  = control_q[`BIT_MACHINE_CHECK_EN];

  // event classification
  wire         fill_dbl  = FILL_ERR & FILL_DOUBLE;
  wire         fill_sgl  = FILL_ERR & ~FILL_DOUBLE & FILL_FROM_MEM;
  wire         ifill_sgl = fill_sgl & FILL_ICACHE;
  wire         dfill_sgl = fill_sgl & ~FILL_ICACHE;
  wire         dfill_raw = dfill_sgl & ~FILL_LOAD_USED;
  wire         dfill_use = dfill_sgl & FILL_LOAD_USED & ~FILL_SPECULATIVE;
  wire         dfill_spc = dfill_sgl & FILL_LOAD_USED & FILL_SPECULATIVE;
  wire         victim_crd = VICTIM_ECC_ERR & ~VICTIM_EVICT_BLOCK; // [R1] [R2]
  wire         flow_idle = (flow_q == FL_IDLE);
  wire         flow_go   = dfill_use & flow_idle;

  // source code for the log; speculative and victim cases log nothing
  wire err_code_e dbl_code = FILL_ICACHE ?
                    (FILL_FROM_MEM ? ERR_IFETCH_MEM2 : ERR_IFETCH_SEC2) :
                    (FILL_FROM_MEM ? ERR_DFETCH_MEM2 : ERR_DFETCH_SEC2); // [R15]
  wire err_code_e log_code = fill_dbl  ? dbl_code :
                             ifill_sgl ? ERR_IFETCH_MEM1 : // [R4]
                             (dfill_raw | dfill_use) ? ERR_DFETCH_MEM1 : // [R8] [R12]
                             PROBE_ERR ? ERR_PROBE_SEC1 : ERR_NONE; // [R14] [R13]
  wire         log_free  = (status_q == ERR_NONE) | clr_log;
  wire         log_new   = (log_code != ERR_NONE) & log_free; // [R22]
  wire         syn_new   = log_new & (ifill_sgl | dfill_raw | dfill_use | PROBE_ERR);

  // exception posting
  wire         crd_set  = crd_en & (victim_crd | ifill_sgl | dfill_raw | dfill_spc
                          | PROBE_ERR | ICACHE_PARITY_ERR | (flow_q == FL_RETRY));
  wire         machine_check_set = ifill_sgl | (machine_check_en & (fill_dbl | DTAG_PERR_RETRY)); // [R7] [R16] [R21]
  wire         take_now = machine_check_q & (~PRIVILEGED_FIRMWARE_MODE | imm_q); // [R16]

  // read mux
  wire [31:0]  rd_mux =
    (WB_ADR_I == `OFS_CONTROL)      ? {30'h0, control_q} :
    (WB_ADR_I == `OFS_ERR_STATUS)   ? {28'h0, status_q} :
    (WB_ADR_I == `OFS_ERR_ADDR_LO)  ? addr_q[37:6] :
    (WB_ADR_I == `OFS_ERR_ADDR_HI)  ? {27'h0, addr_q[42:38]} :
    (WB_ADR_I == `OFS_SYNDROME)     ? {16'h0, syn1_q, syn0_q} :
    (WB_ADR_I == `OFS_DCACHE_STAT)  ? {29'h0, dstat_q} :
    (WB_ADR_I == `OFS_IFETCH_STAT)  ? {31'h0, ipar_q} :
    (WB_ADR_I == `OFS_MEMMGMT_STAT) ? {31'h0, dtag_q} :
    (WB_ADR_I == `OFS_FAULT_VA)     ? va_q :
    (WB_ADR_I == `OFS_EVENTS)       ? {30'h0, machine_check_q, crd_q} : 32'h0;

  // wishbone answer one cycle after the request
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end
    else
    begin
      ack_q  <= req & ~ack_q;
      rdat_q <= rd_mux;
    end
  end

  // control register
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      control_q <= `RST_CONTROL;
    else if (wr_ctrl)
      control_q <= WB_DAT_I[1:0];
  end

  // error log: status exact, address with it, syndromes only for single and probe errors
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      status_q <= ERR_NONE;
      addr_q   <= 37'h0;
      syn0_q   <= `RST_SYN;
      syn1_q   <= `RST_SYN;
    end
    else if (log_new)
    begin
      status_q <= log_code; // [R18]
      addr_q   <= ERR_BLOCK_ADDR; // [R5]
      if (syn_new)
      begin
        syn0_q <= ERR_SYN0; // [R6]
        syn1_q <= ERR_SYN1;
      end
    end
    else if (clr_log)
      status_q <= ERR_NONE;
  end

  // sticky status flags, set wins over clear
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      dstat_q <= 3'h0;
      ipar_q  <= 1'b0;
      dtag_q  <= 1'b0;
      va_q    <= 32'h0;
    end
    else
    begin
      dstat_q[`BIT_LOAD_ECC] <= (dstat_q[`BIT_LOAD_ECC] & ~(clr_dst & WB_DAT_I[`BIT_LOAD_ECC]))
                                | flow_go; // [R12]
      dstat_q[`BIT_TPAR_P0]  <= (dstat_q[`BIT_TPAR_P0] & ~(clr_dst & WB_DAT_I[`BIT_TPAR_P0]))
                                | (DTAG_PERR_RETRY & ~DTAG_PERR_PIPE1); // [R21]
      dstat_q[`BIT_TPAR_P1]  <= (dstat_q[`BIT_TPAR_P1] & ~(clr_dst & WB_DAT_I[`BIT_TPAR_P1]))
                                | (DTAG_PERR_RETRY & DTAG_PERR_PIPE1); // [R21]
      ipar_q <= (ipar_q & ~(clr_ist & WB_DAT_I[0])) | ICACHE_PARITY_ERR; // [R19]
      dtag_q <= (dtag_q & ~(clr_mms & WB_DAT_I[0])) | DTAG_PERR_ISSUE; // [R20]
      if (DTAG_PERR_ISSUE)
        va_q <= FAULT_VADDR; // [R20]
    end
  end

  // pending interrupt and machine check
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      crd_q  <= 1'b0;
      machine_check_q <= 1'b0;
      imm_q  <= 1'b0;
      take_q <= 1'b0;
    end
    else
    begin
      crd_q  <= (crd_q & ~(clr_evt & WB_DAT_I[`BIT_CRD_PEND])) | crd_set;
      machine_check_q <= (machine_check_q & ~take_now & ~(clr_evt & WB_DAT_I[`BIT_MACHINE_CHECK_PEND])) | machine_check_set;
      imm_q  <= (imm_q & ~take_now) | ifill_sgl; // [R7]
      take_q <= take_now;
    end
  end

  // load-used correction flow
  always_comb
  begin
    flow_d = flow_q;
    case (flow_q)
      FL_IDLE:  if (dfill_use) flow_d = FL_WAIT; // [R9]
      FL_WAIT:  if (READ_ERR_REQ) flow_d = FL_EVICT; // [R11]
      FL_EVICT: flow_d = FL_WBACK;
      FL_WBACK: flow_d = FL_RETRY;
      FL_RETRY: flow_d = FL_IDLE; // [R12]
      default:  flow_d = FL_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      flow_q <= FL_IDLE;
    else
      flow_q <= flow_d;
  end

  // action pulses
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      fwd_q    <= 1'b0;
      badpar_q <= 1'b0;
      flush_q  <= 1'b0;
      raw_q    <= 1'b0;
      replay_q <= 1'b0;
      fault_q  <= 1'b0;
      hold_q   <= 1'b0;
      evict_q  <= 1'b0;
      wback_q  <= 1'b0;
      retry_q  <= 1'b0;
    end
    else
    begin
      fwd_q    <= VICTIM_ECC_ERR | PROBE_ERR; // [R1] [R3] [R14]
      badpar_q <= ifill_sgl; // [R4]
      flush_q  <= ifill_sgl | ICACHE_PARITY_ERR; // [R4] [R19]
      raw_q    <= dfill_raw | (fill_dbl & FILL_FROM_MEM); // [R8] [R17]
      replay_q <= flow_go; // [R10]
      fault_q  <= DTAG_PERR_ISSUE; // [R20]
      hold_q   <= (flow_d != FL_IDLE); // [R9] [R10]
      evict_q  <= (flow_d == FL_EVICT); // [R11]
      wback_q  <= (flow_d == FL_WBACK); // [R11]
      retry_q  <= (flow_d == FL_RETRY); // [R12]
    end
  end

  // outputs
  assign WB_ACK_O                 = ack_q;
  assign WB_DAT_O                 = rdat_q;
  assign CORRECTED_READ_INTERRUPT = crd_q;
  assign MACHINE_CHECK_POST       = machine_check_q;
  assign MACHINE_CHECK_TAKE       = take_q;
  assign DATA_FAULT               = fault_q;
  assign FORWARD_UNCORRECTED      = fwd_q;
  assign ICACHE_BAD_PARITY        = badpar_q;
  assign ICACHE_FLUSH             = flush_q;
  assign WRITE_RAW_CHECKBITS      = raw_q;
  assign LOADQ_HOLD               = hold_q; // [R9]
  assign REPLAY_TRAP              = replay_q;
  assign MAP_STALL                = hold_q; // [R10]
  assign SCRUB_EVICT              = evict_q; // [R11]
  assign SCRUB_WRITEBACK          = wback_q; // [R11]
  assign LOAD_RETRY               = retry_q; // [R12]

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  wire only_victim = ~FILL_ERR & ~PROBE_ERR & ~clr_log;

  sequence s_scrub;
    SCRUB_EVICT ##1 SCRUB_WRITEBACK ##1 LOAD_RETRY;
  endsequence

  sequence s_ifill;
    ICACHE_FLUSH && ICACHE_BAD_PARITY;
  endsequence

  a_victim_crd: assert property (VICTIM_ECC_ERR && !VICTIM_EVICT_BLOCK && crd_en
    |=> CORRECTED_READ_INTERRUPT && FORWARD_UNCORRECTED) // [R1]
    else $error("victim error did not raise interrupt");
  a_victim_nolog: assert property (VICTIM_ECC_ERR && only_victim
    |=> $stable(status_q)) // [R2]
    else $error("victim error changed the log");
  a_evict_quiet: assert property (VICTIM_EVICT_BLOCK && VICTIM_ECC_ERR && !crd_q
    && !crd_set |=> !CORRECTED_READ_INTERRUPT) // [R3]
    else $error("evict-block victim raised interrupt");
  a_ifill_flush: assert property (ifill_sgl |=> s_ifill) // [R4]
    else $error("icache fill error not flushed");
  a_ifill_take: assert property (ifill_sgl |-> ##2 MACHINE_CHECK_TAKE) // [R7]
    else $error("immediate machine check not taken");
  a_addr_log: assert property (log_new |=> addr_q == $past(ERR_BLOCK_ADDR)) // [R5]
    else $error("fill address not captured");
  a_syn_hold: assert property (status_q != ERR_NONE && !clr_log
    |=> $stable(syn0_q) && $stable(syn1_q) && $stable(status_q)) // [R22]
    else $error("logged record overwritten");
  a_scrub_flow: assert property (flow_q == FL_WAIT && READ_ERR_REQ |=> s_scrub) // [R11]
    else $error("scrub sequence broken");
  a_stall_hold: assert property (REPLAY_TRAP |-> LOADQ_HOLD && MAP_STALL) // [R10]
    else $error("replay without stall");
  a_spec_nolog: assert property (dfill_spc && status_q == ERR_NONE && !PROBE_ERR
    |=> status_q == ERR_NONE) // [R13]
    else $error("speculative error logged");
  a_machine_check_defer: assert property (machine_check_q && PRIVILEGED_FIRMWARE_MODE && !imm_q
    |=> !MACHINE_CHECK_TAKE) // [R16]
    else $error("machine check taken in firmware mode");
  a_dtag_fault: assert property (DTAG_PERR_ISSUE |=> DATA_FAULT && dtag_q) // [R20]
    else $error("tag parity fault missing");

endmodule : fill_ecc_error_logging

// ---- fill_ecc_memside_model.sv ----
`timescale 1ns/100ps
module fill_ecc_memside_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // cycles to wait before the error read
  input  wire logic [4:0] gap,
  // device side
  input  wire logic       replay_trap,
  output logic            read_err_req
);
  logic [5:0] cnt_q;

  // count down from the replay trap, then send one error read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q        <= 6'h00;
      read_err_req <= 1'b0;
    end
    else
    begin
      read_err_req <= (cnt_q == 6'h01);
      if (replay_trap)
        cnt_q <= {1'b0, gap} + 6'h01;
      else if (cnt_q != 6'h00)
        cnt_q <= cnt_q - 6'h01;
    end
  end
endmodule : fill_ecc_memside_model

// ---- test_fill_ecc_error_logging.sv ----
`timescale 1ns/100ps
`include "fill_ecc_regs.svh"
module test_fill_ecc_error_logging;
  // clock, reset and bus
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O;
  // event data
  logic [42:6] ERR_BLOCK_ADDR = 37'h0;
  logic [7:0]  ERR_SYN0 = 8'h00;
  logic [7:0]  ERR_SYN1 = 8'h00;
  logic [31:0] FAULT_VADDR = 32'h0;
  logic        PRIVILEGED_FIRMWARE_MODE = 1'b1;
  logic        READ_ERR_REQ;
  logic [12:0] ev_q = 13'h0;
  logic        VICTIM_ECC_ERR, VICTIM_EVICT_BLOCK, FILL_ERR, FILL_DOUBLE, FILL_ICACHE;
  logic        FILL_FROM_MEM, FILL_LOAD_USED, FILL_SPECULATIVE, PROBE_ERR;
  logic        ICACHE_PARITY_ERR, DTAG_PERR_ISSUE, DTAG_PERR_RETRY, DTAG_PERR_PIPE1;
  // design outputs
  logic        CORRECTED_READ_INTERRUPT, MACHINE_CHECK_POST, MACHINE_CHECK_TAKE;
  logic        DATA_FAULT, FORWARD_UNCORRECTED, ICACHE_BAD_PARITY, ICACHE_FLUSH;
  logic        WRITE_RAW_CHECKBITS, LOADQ_HOLD, REPLAY_TRAP, MAP_STALL;
  logic        SCRUB_EVICT, SCRUB_WRITEBACK, LOAD_RETRY;
  // bench state
  logic [9:0]  seen = 10'h0;
  logic        clr = 1'b0;
  logic [4:0]  gap = 5'h00;
  logic [23:0] r;
  logic [31:0] act;
  logic [7:0]  k;
  int          n;
  int          num_errors = 0;
  int          cmp_count = 0;
  // rows: events, status, {machine_check,crd} pending, action mask, actions
  localparam logic [23:0] rows [11] = '{24'h800188, 24'hC00088, 24'h2C05E6,
    24'h240911, 24'h270100, 24'h008D88, 24'h381200, 24'h301600, 24'h3C1A11,
    24'h341E11, 24'h004122};

  // event pulses from one vector
  assign {DTAG_PERR_ISSUE, DTAG_PERR_RETRY, DTAG_PERR_PIPE1, VICTIM_ECC_ERR,
          VICTIM_EVICT_BLOCK, FILL_ERR, FILL_DOUBLE, FILL_ICACHE, FILL_FROM_MEM,
          FILL_LOAD_USED, FILL_SPECULATIVE, PROBE_ERR, ICACHE_PARITY_ERR} = ev_q;

  fill_ecc_error_logging u_dut
  (
    .CLOCK                    (CLOCK),
    .RST                      (RST),
    .WB_CYC_I                 (WB_CYC_I),
    .WB_STB_I                 (WB_STB_I),
    .WB_WE_I                  (WB_WE_I),
    .WB_ADR_I                 (WB_ADR_I),
    .WB_SEL_I                 (WB_SEL_I),
    .WB_DAT_I                 (WB_DAT_I),
    .WB_DAT_O                 (WB_DAT_O),
    .WB_ACK_O                 (WB_ACK_O),
    .VICTIM_ECC_ERR           (VICTIM_ECC_ERR),
    .VICTIM_EVICT_BLOCK       (VICTIM_EVICT_BLOCK),
    .FILL_ERR                 (FILL_ERR),
    .FILL_DOUBLE              (FILL_DOUBLE),
    .FILL_ICACHE              (FILL_ICACHE),
    .FILL_FROM_MEM            (FILL_FROM_MEM),
    .FILL_LOAD_USED           (FILL_LOAD_USED),
    .FILL_SPECULATIVE         (FILL_SPECULATIVE),
    .PROBE_ERR                (PROBE_ERR),
    .ERR_BLOCK_ADDR           (ERR_BLOCK_ADDR),
    .ERR_SYN0                 (ERR_SYN0),
    .ERR_SYN1                 (ERR_SYN1),
    .READ_ERR_REQ             (READ_ERR_REQ),
    .ICACHE_PARITY_ERR        (ICACHE_PARITY_ERR),
    .DTAG_PERR_ISSUE          (DTAG_PERR_ISSUE),
    .DTAG_PERR_RETRY          (DTAG_PERR_RETRY),
    .DTAG_PERR_PIPE1          (DTAG_PERR_PIPE1),
    .FAULT_VADDR              (FAULT_VADDR),
    .PRIVILEGED_FIRMWARE_MODE (PRIVILEGED_FIRMWARE_MODE),
    .CORRECTED_READ_INTERRUPT (CORRECTED_READ_INTERRUPT),
    .MACHINE_CHECK_POST       (MACHINE_CHECK_POST),
    .MACHINE_CHECK_TAKE       (MACHINE_CHECK_TAKE),
    .DATA_FAULT               (DATA_FAULT),
    .FORWARD_UNCORRECTED      (FORWARD_UNCORRECTED),
    .ICACHE_BAD_PARITY        (ICACHE_BAD_PARITY),
    .ICACHE_FLUSH             (ICACHE_FLUSH),
    .WRITE_RAW_CHECKBITS      (WRITE_RAW_CHECKBITS),
    .LOADQ_HOLD               (LOADQ_HOLD),
    .REPLAY_TRAP              (REPLAY_TRAP),
    .MAP_STALL                (MAP_STALL),
    .SCRUB_EVICT              (SCRUB_EVICT),
    .SCRUB_WRITEBACK          (SCRUB_WRITEBACK),
    .LOAD_RETRY               (LOAD_RETRY)
  );

  fill_ecc_memside_model u_mem
  (
    .clk          (CLOCK),
    .rst          (RST),
    .gap          (gap),
    .replay_trap  (REPLAY_TRAP),
    .read_err_req (READ_ERR_REQ)
  );

  // clock
  always #2 CLOCK = ~CLOCK;

  // collect action pulses since the last event
  always @(posedge CLOCK)
    seen <= clr ? 10'h0 : seen | {FORWARD_UNCORRECTED, ICACHE_BAD_PARITY, ICACHE_FLUSH,
      WRITE_RAW_CHECKBITS, REPLAY_TRAP, DATA_FAULT, SCRUB_EVICT, SCRUB_WRITEBACK,
      LOAD_RETRY, MACHINE_CHECK_TAKE};

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int t;
    t = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do
    begin
      @(posedge CLOCK);
      t++;
    end
    while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    chk("ack delay", 32'h2, t);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLOCK);
    chk("ack drop", 32'h0, {31'h0, WB_ACK_O});
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic fire(input logic [12:0] e, input logic [7:0] id, input int w);
    ev_q <= e;
    ERR_BLOCK_ADDR <= {5'h15, 24'hA5A500, id};
    ERR_SYN0 <= id;
    ERR_SYN1 <= ~id;
    FAULT_VADDR <= {24'hFACE00, id};
    clr <= 1'b1;
    @(posedge CLOCK);
    ev_q <= 13'h0;
    clr <= 1'b0;
    repeat (w) @(posedge CLOCK);
  endtask : fire

  task automatic tally_and_finish();
    $display("TB: errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // watchdog
  initial
  begin
    repeat (5000) @(posedge CLOCK);
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(`OFS_CONTROL, 32'h3, "control");
    rd(`OFS_ERR_STATUS, 32'h0, "status");
    // a write without byte lane 0 leaves control alone
    WB_SEL_I <= 4'hE;
    wr(`OFS_CONTROL, 32'h0);
    WB_SEL_I <= 4'hF;
    rd(`OFS_CONTROL, 32'h3, "control sel");
    for (int i = 0; i < 11; i++)
    begin
      r = rows[i];
      k = i[7:0];
      fire({3'b000, r[23:14]}, k, 4);
      act = {28'h0, seen[9:6] & r[7:4]};
      chk("actions", {28'h0, r[3:0]}, act);
      chk("crd pin", {31'h0, r[8]}, {31'h0, CORRECTED_READ_INTERRUPT});
      chk("machine_check pin", {31'h0, r[9]}, {31'h0, MACHINE_CHECK_POST});
      rd(`OFS_ERR_STATUS, {28'h0, r[13:10]}, "status");
      rd(`OFS_EVENTS, {30'h0, r[9:8]}, "pending");
      if (r[13:10] != 4'h0)
        rd(`OFS_ERR_ADDR_LO, {24'hA5A500, k}, "address");
      if (r[13:10] != 4'h0 && r[13:10] < 4'h4)
        rd(`OFS_SYNDROME, {16'h0, ~k, k}, "syndromes");
      wr(`OFS_ERR_STATUS, 32'h0);
      wr(`OFS_EVENTS, 32'h3);
    end
    // icache parity flag left by the last row, then cleared
    rd(`OFS_IFETCH_STAT, 32'h1, "parity flag");
    wr(`OFS_IFETCH_STAT, 32'h1);
    rd(`OFS_IFETCH_STAT, 32'h0, "parity clear");
    // first record survives a second error
    fire(13'h0090, 8'h28, 1);
    fire(13'h00D0, 8'h29, 4);
    rd(`OFS_ERR_STATUS, 32'h2, "status");
    rd(`OFS_ERR_ADDR_LO, 32'hA5A50028, "address");
    rd(`OFS_SYNDROME, 32'h0000D728, "syndromes");
    wr(`OFS_ERR_STATUS, 32'h0);
    wr(`OFS_EVENTS, 32'h3);
    // load-used correction, prompt and slow error read
    for (int g = 0; g < 2; g++)
    begin
      gap <= (g == 0) ? 5'h00 : 5'h14;
      fire(13'h0098, 8'h32, 1);
      chk("hold", 32'h3, {30'h0, LOADQ_HOLD, MAP_STALL});
      n = 0;
      while (seen[1] !== 1'b1 && n < 100)
      begin
        @(posedge CLOCK);
        n++;
      end
      repeat (2) @(posedge CLOCK);
      chk("flow", 32'hF, {28'h0, seen[5], seen[3:1]});
      chk("release", 32'h0, {30'h0, LOADQ_HOLD, MAP_STALL});
      rd(`OFS_ERR_STATUS, 32'h2, "status");
      rd(`OFS_DCACHE_STAT, 32'h1, "load flag");
      rd(`OFS_EVENTS, 32'h1, "pending");
      wr(`OFS_ERR_STATUS, 32'h0);
      wr(`OFS_DCACHE_STAT, 32'h1);
      wr(`OFS_EVENTS, 32'h3);
    end
    // tag parity at issue and on retry
    fire(13'h1000, 8'h3C, 4);
    chk("data fault", 32'h1, {31'h0, seen[4]});
    rd(`OFS_MEMMGMT_STAT, 32'h1, "tag flag");
    rd(`OFS_FAULT_VA, 32'hFACE003C, "fault va");
    wr(`OFS_MEMMGMT_STAT, 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      fire((p == 0) ? 13'h0800 : 13'h0C00, 8'h3D, 4);
      rd(`OFS_DCACHE_STAT, (p == 0) ? 32'h2 : 32'h4, "pipe flag");
      rd(`OFS_EVENTS, 32'h2, "pending");
      wr(`OFS_DCACHE_STAT, 32'h7);
      wr(`OFS_EVENTS, 32'h3);
    end
    // machine check taken outside firmware mode, then disabled
    PRIVILEGED_FIRMWARE_MODE <= 1'b0;
    fire(13'h00D0, 8'h46, 4);
    chk("take", 32'h1, {31'h0, seen[0]});
    rd(`OFS_EVENTS, 32'h0, "pending");
    rd(`OFS_ERR_ADDR_HI, 32'h15, "address hi");
    rd(`OFS_ERR_STATUS, 32'h7, "status");
    wr(`OFS_ERR_STATUS, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
    fire(13'h00D0, 8'h47, 4);
    chk("no take", 32'h0, {31'h0, seen[0]});
    rd(`OFS_EVENTS, 32'h0, "pending");
    wr(`OFS_ERR_STATUS, 32'h0);
    wr(`OFS_CONTROL, 32'h0);
    fire(13'h0200, 8'h48, 4);
    rd(`OFS_EVENTS, 32'h0, "pending");
    rd(8'h3C, 32'h0, "unmapped");
    tally_and_finish();
  end
endmodule : test_fill_ecc_error_logging
